// ### erf_map.svh
// Register offsets, field positions, reset values and frame constants of the receive filter.
`ifndef ERF_MAP_SVH
`define ERF_MAP_SVH

`define ERF_OFF_CTRL 8'h00
`define ERF_OFF_STATION_LO 8'h04
`define ERF_OFF_STATION_HI 8'h08
`define ERF_OFF_PAT_OFFSET 8'h0c
`define ERF_OFF_PAT_MASK_LO 8'h10
`define ERF_OFF_PAT_MASK_HI 8'h14
`define ERF_OFF_PAT_CSUM 8'h18
`define ERF_OFF_HASH_LO 8'h1c
`define ERF_OFF_HASH_HI 8'h20
`define ERF_OFF_STATUS 8'h24

`define ERF_BIT_STATION 7
`define ERF_BIT_COMBINE 6
`define ERF_BIT_FCS 5
`define ERF_BIT_PATTERN 4
`define ERF_BIT_WAKEUP 3
`define ERF_BIT_HASH 2
`define ERF_BIT_GROUP 1
`define ERF_BIT_ALL_ONES 0
`define ERF_TEST_MASK 8'h9f

`define ERF_RST_CTRL 8'ha1

`define ERF_DA_BYTES 16'd6
`define ERF_DATA_START 16'd14
`define ERF_SYNC_BYTES 3'd6
`define ERF_WAKE_REPS 5'd16
`define ERF_WINDOW 17'd64
`define ERF_HASH_HI 28
`define ERF_HASH_LO 23
`define ERF_CRC_POLY 32'hedb88320
`define ERF_CRC_INIT 32'hffffffff

`endif

// ### erf_pkg.sv
// Types shared by the receive filter modules.
`include "erf_map.svh"

package erf_pkg;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_frame = 1'b1
    } erf_state_t;

    typedef struct packed {
        logic [31:0] crc;
    } erf_crc_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [47:0] station;
        logic [15:0] pat_off;
        logic [63:0] pat_mask;
        logic [15:0] pat_csum;
        logic [63:0] hash_tbl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        erf_state_t st;
        logic [15:0] pos;
        logic [47:0] dst;
        logic [15:0] sum;
        logic odd;
        logic [2:0] ff_cnt;
        logic [2:0] wk_byte;
        logic [4:0] wk_rep;
        logic wk_hit;
        logic verdict_valid;
        logic verdict_accept;
        logic [7:0] last_pass;
        logic [7:0] accept_cnt;
    } erf_regs_t;

endpackage

// ### erf_crc32.sv
// Byte-wide CRC-32 engine used to hash the destination address.
`timescale 1ns/1ps

module erf_crc32 (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Byte stream.
    input wire logic start,
    input wire logic enable,
    input wire logic [7:0] data,
    // Running remainder.
    output logic [31:0] crc
);
    erf_pkg::erf_crc_t r;
    erf_pkg::erf_crc_t next_r;

    // Reflected CRC, least significant bit first, no final inversion.
    function automatic logic [31:0] step(input logic [31:0] seed, input logic [7:0] b);
        logic [31:0] c;
        c = seed ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `ERF_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    always_comb begin
        next_r = r;
        if (enable) begin
            next_r.crc = step(start ? `ERF_CRC_INIT : r.crc, data);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{crc: `ERF_CRC_INIT};
        end else begin
            r <= next_r;
        end
    end

    assign crc = r.crc;

    AST_CRC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> $stable(r.crc)) else $error("hash remainder moved without a byte");
endmodule

// ### erf_receive_filter.sv
// Receive packet filter with APB register access.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module erf_receive_filter #(
    parameter int WINDOW_BYTES = 64,
    parameter int HASH_ENTRIES = 64
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received byte stream from the physical layer.
    input wire logic rx_valid,
    input wire logic rx_first,
    input wire logic rx_last,
    input wire logic [7:0] rx_data,
    input wire logic rx_fcs_ok,
    // Frame verdict.
    output logic verdict_valid,
    output logic verdict_accept
);
    if (WINDOW_BYTES != 64 || HASH_ENTRIES != 64) begin : g_bad_size
        $error("window and hash table are fixed at 64 entries");
    end

    erf_pkg::erf_regs_t r;
    erf_pkg::erf_regs_t next_r;
    logic [31:0] crc;
    logic [7:0] pass;
    logic done;
    logic apb_write;
    logic apb_access;
    logic [15:0] p;
    logic [15:0] rel;
    logic [16:0] win_end;
    logic in_win;
    logic [15:0] word;
    logic [16:0] sum17;
    logic [5:0] hash_idx;
    logic combined;
    logic keep;

    // The remainder freezes after the sixth address byte and stands until the next first byte.
    erf_crc32 u_hash_crc (
        .pclk(pclk),
        .presetn(presetn),
        .start(rx_valid && rx_first),
        .enable(rx_valid && (rx_first || (r.st == erf_pkg::st_frame && r.pos < `ERF_DA_BYTES))),
        .data(rx_data),
        .crc(crc)
    );

    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite && r.pready;

    always_comb begin
        next_r = r;
        p = rx_first ? 16'h0000 : r.pos;
        rel = p - r.pat_off;
        in_win = (p >= r.pat_off) && (rel < 16'(WINDOW_BYTES));
        word = 16'h0000;
        sum17 = 17'h00000;
        done = 1'b0;
        next_r.verdict_valid = 1'b0;

        // Register access: the answer is registered, so every transfer takes one wait state.
        next_r.pready = apb_access && !r.pready;
        if (apb_access && !r.pready) begin
            next_r.pslverr = 1'b0;
            case (paddr)
                `ERF_OFF_CTRL: next_r.prdata = {24'h000000, r.ctrl};
                `ERF_OFF_STATION_LO: next_r.prdata = r.station[31:0];
                `ERF_OFF_STATION_HI: next_r.prdata = {16'h0000, r.station[47:32]};
                `ERF_OFF_PAT_OFFSET: next_r.prdata = {16'h0000, r.pat_off};
                `ERF_OFF_PAT_MASK_LO: next_r.prdata = r.pat_mask[31:0];
                `ERF_OFF_PAT_MASK_HI: next_r.prdata = r.pat_mask[63:32];
                `ERF_OFF_PAT_CSUM: next_r.prdata = {16'h0000, r.pat_csum};
                `ERF_OFF_HASH_LO: next_r.prdata = r.hash_tbl[31:0];
                `ERF_OFF_HASH_HI: next_r.prdata = r.hash_tbl[63:32];
                `ERF_OFF_STATUS: next_r.prdata = {8'h00, r.accept_cnt, r.last_pass,
                                                  7'h00, r.verdict_accept};
                default: begin
                    next_r.prdata = 32'h00000000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_write) begin
            case (paddr)
                `ERF_OFF_CTRL: next_r.ctrl = pwdata[7:0];
                `ERF_OFF_STATION_LO: next_r.station[31:0] = pwdata;
                `ERF_OFF_STATION_HI: next_r.station[47:32] = pwdata[15:0];
                `ERF_OFF_PAT_OFFSET: next_r.pat_off = pwdata[15:0];
                `ERF_OFF_PAT_MASK_LO: next_r.pat_mask[31:0] = pwdata;
                `ERF_OFF_PAT_MASK_HI: next_r.pat_mask[63:32] = pwdata;
                `ERF_OFF_PAT_CSUM: next_r.pat_csum = pwdata[15:0];
                `ERF_OFF_HASH_LO: next_r.hash_tbl[31:0] = pwdata;
                `ERF_OFF_HASH_HI: next_r.hash_tbl[63:32] = pwdata;
                default: next_r.ctrl = r.ctrl;
            endcase
        end

        // Frame walk. A first byte always restarts, so a truncated frame cannot leak state.
        if (rx_valid && (rx_first || r.st == erf_pkg::st_frame)) begin
            if (rx_first) begin
                next_r.dst = 48'h000000000000;
                next_r.sum = 16'h0000;
                next_r.odd = 1'b0;
                next_r.ff_cnt = 3'd0;
                next_r.wk_byte = 3'd0;
                next_r.wk_rep = 5'd0;
                next_r.wk_hit = 1'b0;
            end
            next_r.st = erf_pkg::st_frame;
            next_r.pos = p + 16'h0001;
            if (p < `ERF_DA_BYTES) begin
                next_r.dst[{p[2:0], 3'b000} +: 8] = rx_data;
            end
            // Only bytes with their mask bit set advance the word alignment.
            if (in_win && r.pat_mask[rel[5:0]]) begin
                word = next_r.odd ? {8'h00, rx_data} : {rx_data, 8'h00};
                sum17 = {1'b0, next_r.sum} + {1'b0, word};
                next_r.sum = sum17[15:0] + {15'h0000, sum17[16]};
                next_r.odd = !next_r.odd;
            end
            // Sync run of all-ones bytes, then sixteen station address copies.
            if (p >= `ERF_DATA_START && !next_r.wk_hit) begin
                if (next_r.wk_byte != 3'd0 || next_r.wk_rep != 5'd0) begin
                    if (rx_data == r.station[{next_r.wk_byte, 3'b000} +: 8]) begin
                        if (next_r.wk_byte == 3'd5) begin
                            next_r.wk_byte = 3'd0;
                            next_r.wk_rep = next_r.wk_rep + 5'd1;
                            next_r.wk_hit = (next_r.wk_rep == `ERF_WAKE_REPS);
                        end else begin
                            next_r.wk_byte = next_r.wk_byte + 3'd1;
                        end
                    end else begin
                        next_r.wk_byte = 3'd0;
                        next_r.wk_rep = 5'd0;
                        next_r.ff_cnt = (rx_data == 8'hff) ? 3'd1 : 3'd0;
                    end
                end else if (next_r.ff_cnt == `ERF_SYNC_BYTES
                             && rx_data == r.station[7:0]) begin
                    next_r.wk_byte = 3'd1;
                end else if (rx_data == 8'hff) begin
                    if (next_r.ff_cnt != `ERF_SYNC_BYTES) begin
                        next_r.ff_cnt = next_r.ff_cnt + 3'd1;
                    end
                end else begin
                    next_r.ff_cnt = 3'd0;
                end
            end
            if (rx_last) begin
                done = 1'b1;
                next_r.st = erf_pkg::st_idle;
            end
        end

        // Live control values are used, so a write during a frame applies at its last byte.
        // Test results, taken from the state that includes the last byte.
        win_end = {1'b0, r.pat_off} + `ERF_WINDOW;
        hash_idx = crc[`ERF_HASH_HI:`ERF_HASH_LO];
        pass = 8'h00;
        pass[`ERF_BIT_STATION] = (next_r.dst == r.station);
        pass[`ERF_BIT_PATTERN] = ({1'b0, next_r.pos} >= win_end)
                                 && (~next_r.sum == r.pat_csum);
        pass[`ERF_BIT_WAKEUP] = pass[`ERF_BIT_STATION] && next_r.wk_hit;
        pass[`ERF_BIT_HASH] = r.hash_tbl[hash_idx];
        pass[`ERF_BIT_GROUP] = next_r.dst[0];
        pass[`ERF_BIT_ALL_ONES] = &next_r.dst;

        if (r.ctrl[`ERF_BIT_COMBINE]) begin
            combined = &(~(r.ctrl & `ERF_TEST_MASK) | pass);
        end else begin
            combined = |(r.ctrl & `ERF_TEST_MASK & pass);
        end
        if (r.ctrl == 8'h00) begin
            keep = 1'b1;
        end else begin
            keep = combined && !(r.ctrl[`ERF_BIT_FCS] && !rx_fcs_ok);
        end

        if (done) begin
            next_r.verdict_valid = 1'b1;
            next_r.verdict_accept = keep;
            next_r.last_pass = pass;
            if (keep) begin
                next_r.accept_cnt = r.accept_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{ctrl: `ERF_RST_CTRL, st: erf_pkg::st_idle, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign verdict_valid = r.verdict_valid;
    assign verdict_accept = r.verdict_accept;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_wait;
        psel && penable && !pready;
    endsequence

    // A frame ends on the byte flagged last, whether bytes come back to back or with gaps.
    sequence s_last_byte;
        rx_valid && rx_last && (rx_first || r.st == erf_pkg::st_frame);
    endsequence

    // Every access takes exactly one wait state, so software timing is fixed.
    AST_APB_ANSWER: assert property (s_setup ##1 s_wait |=> pready)
        else $error("access phase not answered after one wait state");

    AST_APB_PULSE: assert property (
        pready |=> !pready)
        else $error("ready stood for more than one cycle");

    // Read data must stand after the transfer, since a slow master may take it late.
    AST_READ_HOLD: assert property (
        !(psel && penable) |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved outside an access");

    AST_APB_WRITE: assert property (
        psel && penable && pready && pwrite && paddr == `ERF_OFF_CTRL
        |=> r.ctrl == $past(pwdata[7:0]))
        else $error("control write not stored");

    AST_PROMISC: assert property (
        done && r.ctrl == 8'h00 |=> verdict_valid && verdict_accept)
        else $error("cleared control did not accept");

    AST_AND_REJECT: assert property (
        done && r.ctrl[`ERF_BIT_COMBINE]
        && ((r.ctrl & `ERF_TEST_MASK & ~pass) != 8'h00) |=> verdict_valid && !verdict_accept)
        else $error("AND mode kept a frame failing an enabled test");

    AST_AND_KEEP: assert property (
        done && r.ctrl[`ERF_BIT_COMBINE] && ((r.ctrl & `ERF_TEST_MASK & ~pass) == 8'h00)
        && !(r.ctrl[`ERF_BIT_FCS] && !rx_fcs_ok) |=> verdict_accept)
        else $error("AND mode dropped a frame that every enabled test passed");

    AST_OR_KEEP: assert property (
        done && !r.ctrl[`ERF_BIT_COMBINE]
        && !r.ctrl[`ERF_BIT_FCS] && ((r.ctrl & `ERF_TEST_MASK & pass) != 8'h00)
        |=> verdict_accept) else $error("OR mode dropped a passing frame");

    AST_OR_REJECT: assert property (
        done && !r.ctrl[`ERF_BIT_COMBINE] && r.ctrl != 8'h00
        && ((r.ctrl & `ERF_TEST_MASK & pass) == 8'h00) |=> !verdict_accept)
        else $error("OR mode kept a frame no test passed");

    AST_FCS_DROP: assert property (
        done && r.ctrl != 8'h00 && r.ctrl[`ERF_BIT_FCS]
        && !rx_fcs_ok |=> verdict_valid && !verdict_accept)
        else $error("bad FCS frame kept");

    AST_FCS_IGNORED: assert property (
        done && r.ctrl != 8'h00 && !r.ctrl[`ERF_BIT_FCS] |=> verdict_accept == $past(combined))
        else $error("FCS state changed the verdict with the check disabled");

    AST_STATION_MISS: assert property (
        done && r.ctrl == 8'h80 && next_r.dst != r.station |=> !verdict_accept)
        else $error("station test kept a foreign destination");

    // Masked-out bytes must leave both the sum and the byte pairing alone.
    AST_MASK_SKIP: assert property (
        !rx_first && !(in_win && r.pat_mask[rel[5:0]]) |=> $stable(r.sum) && $stable(r.odd))
        else $error("masked-out byte touched the checksum");

    AST_WINDOW_SHORT: assert property (
        done && r.ctrl == 8'h10 && ({1'b0, next_r.pos} < win_end) |=> !verdict_accept)
        else $error("short frame passed pattern test");

    AST_STATION: assert property (
        done && r.ctrl == 8'h08 && next_r.dst != r.station |=> !verdict_accept)
        else $error("wake-up passed without station match");

    AST_WAKE_MISS: assert property (
        done && r.ctrl == 8'h08 && !next_r.wk_hit |=> !verdict_accept)
        else $error("wake-up test kept a frame without the full pattern");

    AST_HASH_MISS: assert property (
        done && r.ctrl == 8'h04 && !r.hash_tbl[hash_idx]
        |=> !verdict_accept)
        else $error("hash test kept a frame whose table bit is clear");

    AST_GROUP_KEEP: assert property (
        done && r.ctrl == 8'h02 && next_r.dst[0] |=> verdict_accept)
        else $error("group test dropped a group address");

    AST_GROUP_ALL_ONES: assert property (
        done |=> r.last_pass[`ERF_BIT_GROUP] == r.dst[0]
        && r.last_pass[`ERF_BIT_ALL_ONES] == (r.dst == 48'hffffffffffff))
        else $error("address class tests wrong");

    // A verdict is a single-cycle pulse unless frames end on consecutive bytes.
    AST_VERDICT_PULSE: assert property (
        verdict_valid |=> !verdict_valid || $past(done))
        else $error("verdict held without a frame end");

    AST_VERDICT_TIME: assert property (
        s_last_byte |=> verdict_valid)
        else $error("no verdict one cycle after the last byte");
endmodule

// ### erf_phy_model.sv
// Behavioural source of received frames, standing in for the physical layer.
`timescale 1ns/1ps

module erf_phy_model (
    // Clock.
    input wire logic pclk,
    // Byte stream towards the filter.
    output logic rx_valid,
    output logic rx_first,
    output logic rx_last,
    output logic [7:0] rx_data,
    output logic rx_fcs_ok
);
    initial begin
        rx_valid = 1'h0;
        rx_first = 1'h0;
        rx_last = 1'h0;
        rx_data = 8'h00;
        rx_fcs_ok = 1'h0;
    end

    // Idle cycles show the inverse of the last byte, so stale data can never pass for a match.
    task automatic send_frame(input logic [7:0] fr[$], input logic fcs_ok, input int gap);
        int n;
        n = fr.size();
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_valid <= 1'h1;
            rx_first <= (i == 0);
            rx_last <= (i == n - 1);
            rx_data <= fr[i];
            rx_fcs_ok <= (i == n - 1) ? fcs_ok : ~fcs_ok;
            for (int g = 0; g < gap && i < n - 1; g++) begin
                @(posedge pclk);
                rx_valid <= 1'h0;
                rx_data <= ~fr[i];
            end
        end
        @(posedge pclk);
        rx_valid <= 1'h0;
        rx_first <= 1'h0;
        rx_last <= 1'h0;
        rx_data <= ~fr[n - 1];
    endtask
endmodule

// ### erf_receive_filter_tb.sv
// Self-checking testbench of the receive filter.
`timescale 1ns/1ps
`include "erf_map.svh"

module erf_receive_filter_tb;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] da;
        logic [7:0] len;
        logic wake;
        logic fcs;
    } erf_row_t;

    localparam logic [47:0] station = 48'h021122334455;
    localparam logic [47:0] src = 48'h0004a3ffffff;
    localparam int nrows = 25;
    localparam erf_row_t rows [nrows] = '{
        '{8'h00, 2'h3, 8'h46, 1'h0, 1'h0},
        '{8'h80, 2'h0, 8'h40, 1'h0, 1'h1},
        '{8'h80, 2'h3, 8'h40, 1'h0, 1'h1},
        '{8'h01, 2'h1, 8'h40, 1'h0, 1'h1},
        '{8'h01, 2'h2, 8'h40, 1'h0, 1'h1},
        '{8'h02, 2'h2, 8'h40, 1'h0, 1'h1},
        '{8'h02, 2'h0, 8'h40, 1'h0, 1'h1},
        '{8'h04, 2'h0, 8'h40, 1'h0, 1'h1},
        '{8'h04, 2'h3, 8'h40, 1'h0, 1'h1},
        '{8'h04, 2'h1, 8'h40, 1'h0, 1'h1},
        '{8'h10, 2'h3, 8'h46, 1'h0, 1'h1},
        '{8'h10, 2'h3, 8'h45, 1'h0, 1'h1},
        '{8'h08, 2'h0, 8'h78, 1'h1, 1'h1},
        '{8'h08, 2'h0, 8'h78, 1'h0, 1'h1},
        '{8'h08, 2'h3, 8'h78, 1'h1, 1'h1},
        '{8'hc3, 2'h1, 8'h40, 1'h0, 1'h1},
        '{8'h43, 2'h1, 8'h40, 1'h0, 1'h1},
        '{8'h43, 2'h2, 8'h40, 1'h0, 1'h1},
        '{8'h93, 2'h3, 8'h3c, 1'h0, 1'h1},
        '{8'h93, 2'h2, 8'h3c, 1'h0, 1'h1},
        '{8'h21, 2'h1, 8'h40, 1'h0, 1'h0},
        '{8'h21, 2'h1, 8'h40, 1'h0, 1'h1},
        '{8'h20, 2'h1, 8'h40, 1'h0, 1'h1},
        '{8'h60, 2'h1, 8'h40, 1'h0, 1'h0},
        '{8'h60, 2'h3, 8'h40, 1'h0, 1'h1}
    };

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, rx_data;
    logic [31:0] pwdata, prdata, rd, keep;
    logic rx_valid, rx_first, rx_last, rx_fcs_ok, verdict_valid, verdict_accept;
    logic [63:0] hash_tbl;
    logic [7:0] frame[$];
    int mismatches, cmp_count, pat_min, accepts;

    erf_receive_filter #(.WINDOW_BYTES(64), .HASH_ENTRIES(64)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last), .rx_data(rx_data),
        .rx_fcs_ok(rx_fcs_ok), .verdict_valid(verdict_valid), .verdict_accept(verdict_accept)
    );

    erf_phy_model i_phy (
        .pclk(pclk), .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last),
        .rx_data(rx_data), .rx_fcs_ok(rx_fcs_ok)
    );

    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", name, e, g);
            mismatches++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            mismatches++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [47:0] da_of(input logic [1:0] s);
        case (s)
            2'h0: return station;
            2'h1: return 48'hffffffffffff;
            2'h2: return 48'h01005e000001;
            default: return 48'h0a0b0c0d0e0f;
        endcase
    endfunction

    function automatic logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        c = `ERF_CRC_INIT;
        for (int b = 5; b >= 0; b--) begin
            c = c ^ {24'h000000, d[b * 8 +: 8]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ `ERF_CRC_POLY) : (c >> 1);
        end
        return c[`ERF_HASH_HI:`ERF_HASH_LO];
    endfunction

    function automatic logic expect_acc(input erf_row_t r);
        logic [47:0] d;
        logic [7:0] p, en;
        d = da_of(r.da);
        en = r.ctrl & `ERF_TEST_MASK;
        p = {d == station, 2'h0, 32'(r.len) >= pat_min, r.wake && d == station,
             hash_tbl[hidx(d)], d[40], &d};
        if (r.ctrl == 8'h00)
            return 1'h1;
        if (!(r.ctrl[`ERF_BIT_COMBINE] ? (p & en) == en : |(p & en)))
            return 1'h0;
        return !(r.ctrl[`ERF_BIT_FCS] && !r.fcs);
    endfunction

    // Data field holds the sync run and sixteen address copies when a wake-up frame is asked for.
    task automatic run_frame(input erf_row_t r, input int gap);
        logic e;
        logic [47:0] d;
        e = expect_acc(r);
        d = da_of(r.da);
        frame = {};
        for (int i = 0; i < r.len; i++) begin
            if (i < 6)
                frame.push_back(d[47 - 8 * i -: 8]);
            else if (i < 12)
                frame.push_back(src[47 - 8 * (i - 6) -: 8]);
            else if (r.wake && i >= 14 && i < 20)
                frame.push_back(8'hff);
            else if (r.wake && i >= 20 && i < 116)
                frame.push_back(station[47 - 8 * ((i - 20) % 6) -: 8]);
            else
                frame.push_back(8'h20 + 8'(i % 64));
        end
        i_phy.send_frame(frame, r.fcs, gap);
        @(negedge pclk);
        chk("verdict_valid", 32'h1, {31'h0, verdict_valid});
        chk("verdict_accept", {31'h0, e}, {31'h0, verdict_accept});
        accepts += e;
    endtask

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        cmp_count = 0;
        accepts = 0;
        repeat (3) @(posedge pclk);
        chk("verdict_valid", 32'h0, {31'h0, verdict_valid});
        chk("ready in reset", 32'h0, {31'h0, pready});
        chk("read data in reset", 32'h0, prdata);
        presetn <= 1'h1;
        apb(1'h0, `ERF_OFF_CTRL, 32'h0);
        chk("control reset", {24'h0, `ERF_RST_CTRL}, rd);
        apb(1'h1, 8'h28, 32'h12345678);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(1'h0, 8'h28, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], err});
        apb(1'h1, `ERF_OFF_STATION_LO, 32'h33221102);
        apb(1'h1, `ERF_OFF_STATION_HI, 32'h00005544);
        apb(1'h1, `ERF_OFF_PAT_OFFSET, 32'h00000006);
        apb(1'h1, `ERF_OFF_PAT_MASK_LO, 32'h0000003f);
        apb(1'h1, `ERF_OFF_PAT_MASK_HI, 32'h00000000);
        apb(1'h1, `ERF_OFF_PAT_CSUM, 32'h00005bfc);
        hash_tbl = 64'h1 << hidx(station);
        apb(1'h1, `ERF_OFF_HASH_LO, hash_tbl[31:0]);
        apb(1'h1, `ERF_OFF_HASH_HI, hash_tbl[63:32]);
        apb(1'h0, `ERF_OFF_STATION_LO, 32'h0);
        chk("station low", 32'h33221102, rd);
        pat_min = 70;
        for (int i = 0; i < nrows; i++) begin
            apb(1'h1, `ERF_OFF_CTRL, {24'h0, rows[i].ctrl});
            run_frame(rows[i], i % 2);
        end
        // An odd start with the first window byte masked shifts word pairing if it were summed.
        apb(1'h1, `ERF_OFF_PAT_OFFSET, 32'h00000005);
        apb(1'h1, `ERF_OFF_PAT_MASK_LO, 32'h0000007e);
        apb(1'h1, `ERF_OFF_CTRL, 32'h00000010);
        pat_min = 69;
        run_frame('{8'h10, 2'h3, 8'h45, 1'h0, 1'h1}, 0);
        run_frame('{8'h10, 2'h3, 8'h44, 1'h0, 1'h1}, 1);
        // A long enough frame with a wrong expected sum must still fail.
        apb(1'h1, `ERF_OFF_PAT_CSUM, 32'h00005bfd);
        pat_min = 1000;
        run_frame('{8'h10, 2'h3, 8'h46, 1'h0, 1'h1}, 0);
        apb(1'h0, `ERF_OFF_STATUS, 32'h0);
        keep = rd;
        chk("accepted count", 32'(accepts[7:0]), {24'h0, rd[23:16]});
        apb(1'h1, `ERF_OFF_STATUS, 32'hffffffff);
        chk("status write error", 32'h0, {31'h0, err});
        apb(1'h0, `ERF_OFF_STATUS, 32'h0);
        chk("status after write", keep, rd);
        // Leave an accepted verdict standing so that reset has something to clear.
        apb(1'h1, `ERF_OFF_CTRL, 32'h00000000);
        run_frame('{8'h00, 2'h3, 8'h40, 1'h0, 1'h0}, 1);
        @(posedge pclk);
        presetn <= 1'h0;
        @(negedge pclk);
        chk("accept in reset", 32'h0, {31'h0, verdict_accept});
        chk("ready in mid reset", 32'h0, {31'h0, pready});
        @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `ERF_OFF_CTRL, 32'h0);
        chk("control after reset", {24'h0, `ERF_RST_CTRL}, rd);
        apb(1'h0, `ERF_OFF_STATUS, 32'h0);
        chk("status after reset", 32'h0, rd);
        finish_test();
    end
endmodule
